// ---- dscr_regs.sv ----
`timescale 1ns/10ps
`include "dscr_cfg.svh"

module dscr_regs (
	input  wire logic               clk_sys,
	input  wire logic               nrst,
	input  wire logic               ctrl_serial_data,
	input  wire logic               ctrl_serial_clock,
	input  wire logic               ctrl_latch_strobe,
	input  wire logic               word_clock_in,
	output logic                    [8:0] left_gain,
	output logic                    [8:0] right_gain,
	output dscr_pkg::dscr_mode_t    mode_cfg,
	output dscr_pkg::dscr_fmt_t     fmt_cfg,
	output logic                    sysclk_ratio_select,
	output logic                    channel_is_left
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [3:0] pin_lvl;
	logic [3:0] pin_rise;

	dscr_sync #(
		.W (4)
	) u_sync (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.async_in ({word_clock_in, ctrl_latch_strobe, ctrl_serial_clock, ctrl_serial_data}),
		.level    (pin_lvl),
		.rise     (pin_rise)
	);

	wire data_lvl   = pin_lvl[0];
	wire clk_rise   = pin_rise[1];
	wire latch_rise = pin_rise[2];
	wire wclk_lvl   = pin_lvl[3];

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [`DSCR_WORD_W-1:0] shift_r;
	logic [`DSCR_WORD_W-1:0] shift_nxt;
	logic [7:0]              pend_left_r;
	logic [7:0]              pend_right_r;
	logic [7:0]              applied_left_r;
	logic [7:0]              applied_right_r;
	logic [8:0]              left_gain_r;
	logic [8:0]              right_gain_r;
	dscr_pkg::dscr_mode_t    mode_r;
	dscr_pkg::dscr_fmt_t     fmt_r;
	logic                    sys_r;
	logic                    chan_left_r;

	// ----------------------------------------
	// step to gain numerator
	// ----------------------------------------
	function automatic logic [8:0] step_gain(input logic [7:0] step);
		step_gain = (step == `DSCR_STEP_MAX) ? `DSCR_GAIN_FULL : {1'b0, step};
	endfunction : step_gain

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire [1:0] word_addr = shift_r[`DSCR_ADDR_HI:`DSCR_ADDR_LO];
	wire [7:0] word_step = shift_r[`DSCR_STEP_HI:0];
	wire       word_load = shift_r[`DSCR_LOAD_BIT];
	wire       wr_left   = latch_rise && (word_addr == `DSCR_ADDR_LEFT);
	wire       wr_right  = latch_rise && (word_addr == `DSCR_ADDR_RIGHT);
	wire       wr_mode   = latch_rise && (word_addr == `DSCR_ADDR_MODE);
	wire       wr_fmt    = latch_rise && (word_addr == `DSCR_ADDR_FMT);
	wire       do_load   = (wr_left || wr_right) && word_load;

	// the word being written is already pending when the flag applies it
	wire [7:0] left_src  = wr_left  ? word_step : pend_left_r;
	wire [7:0] right_src = wr_right ? word_step : pend_right_r;

	// reserved positions B15..B11, and B5..B3 of the format word, are simply not looked at
	wire dscr_pkg::dscr_mode_t mode_nxt =
		dscr_pkg::dscr_mode_t'(shift_r[`DSCR_MODE_HI:0]);
	wire dscr_pkg::dscr_fmt_t  fmt_nxt = '{
		zero_detect_enable:   shift_r[`DSCR_ZDET_BIT],
		rate_group_select:    dscr_pkg::dscr_rate_t'(shift_r[`DSCR_RATE_HI:`DSCR_RATE_LO]),
		atten_common_control: shift_r[`DSCR_ATC_BIT],
		word_clock_polarity:  shift_r[`DSCR_POL_BIT],
		audio_format_select:  shift_r[`DSCR_FMT_BIT]
	};

	// common control reuses the left step for the right output
	wire [7:0] right_eff = fmt_r.atten_common_control ? applied_left_r
	                                                  : applied_right_r;

	assign shift_nxt = {shift_r[`DSCR_WORD_W-2:0], data_lvl};

	// ----------------------------------------
	// serial shifter
	// ----------------------------------------
	// no bit counter: the last sixteen bits before the strobe form the word
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			shift_r <= '0;
		end else if (clk_rise) begin
			shift_r <= shift_nxt;
		end
	end

	// ----------------------------------------
	// attenuation registers
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pend_left_r  <= `DSCR_STEP_RST;
			pend_right_r <= `DSCR_STEP_RST;
		end else begin
			pend_left_r  <= left_src;
			pend_right_r <= right_src;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			applied_left_r  <= `DSCR_STEP_RST;
			applied_right_r <= `DSCR_STEP_RST;
		end else if (do_load) begin
			applied_left_r  <= left_src;
			applied_right_r <= right_src;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			left_gain_r  <= `DSCR_GAIN_FULL;
			right_gain_r <= `DSCR_GAIN_FULL;
		end else begin
			left_gain_r  <= step_gain(applied_left_r);
			right_gain_r <= step_gain(right_eff);
		end
	end

	// ----------------------------------------
	// mode and format registers
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mode_r.output_route_select <= `DSCR_ROUTE_RST;
			mode_r.word_length_select  <= dscr_pkg::DSCR_WL_16;
			mode_r.operation_enable    <= 1'b0;
			mode_r.deemphasis_enable   <= 1'b0;
			mode_r.soft_mute           <= 1'b0;
		end else if (wr_mode) begin
			mode_r <= mode_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			fmt_r.zero_detect_enable   <= 1'b0;
			fmt_r.rate_group_select    <= dscr_pkg::DSCR_SR_441;
			fmt_r.atten_common_control <= 1'b0;
			fmt_r.word_clock_polarity  <= 1'b0;
			fmt_r.audio_format_select  <= 1'b0;
		end else if (wr_fmt) begin
			fmt_r <= fmt_nxt;
		end
	end

	// clock ratio has no field in the word, so it stays at its reset choice
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sys_r <= `DSCR_SYS_RST;
		end else begin
			sys_r <= sys_r;
		end
	end

	// ----------------------------------------
	// word clock phase
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			chan_left_r <= 1'b0;
		end else begin
			chan_left_r <= wclk_lvl ^ fmt_r.word_clock_polarity;
		end
	end

	assign left_gain           = left_gain_r;
	assign right_gain          = right_gain_r;
	assign mode_cfg            = mode_r;
	assign fmt_cfg             = fmt_r;
	assign sysclk_ratio_select = sys_r;
	assign channel_is_left     = chan_left_r;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_load_word;
		latch_rise && (word_addr inside {`DSCR_ADDR_LEFT, `DSCR_ADDR_RIGHT}) && word_load;
	endsequence

	sequence s_hold_word;
		latch_rise && (word_addr inside {`DSCR_ADDR_LEFT, `DSCR_ADDR_RIGHT}) && !word_load;
	endsequence

	property p_shift_msb_first;
		@(posedge clk_sys) disable iff (!nrst)
		clk_rise |=> (shift_r == {$past(shift_r[14:0]), $past(data_lvl)});
	endproperty
	a_shift_msb_first: assert property (p_shift_msb_first)
		else $error("shift register did not take one bit");

	property p_commit_on_strobe;
		@(posedge clk_sys) disable iff (!nrst)
		!latch_rise |=> ($stable(mode_r) && $stable(fmt_r) && $stable(pend_left_r));
	endproperty
	a_commit_on_strobe: assert property (p_commit_on_strobe)
		else $error("register changed without a strobe");

	property p_left_write;
		@(posedge clk_sys) disable iff (!nrst)
		(latch_rise && word_addr == `DSCR_ADDR_LEFT) |=>
			(pend_left_r == $past(shift_r[7:0])) && $stable(pend_right_r);
	endproperty
	a_left_write: assert property (p_left_write)
		else $error("left step not stored from address 00");

	property p_right_write;
		@(posedge clk_sys) disable iff (!nrst)
		(latch_rise && word_addr == `DSCR_ADDR_RIGHT) |=>
			(pend_right_r == $past(shift_r[7:0])) && $stable(pend_left_r);
	endproperty
	a_right_write: assert property (p_right_write)
		else $error("right step not stored from address 01");

	property p_load_applies;
		@(posedge clk_sys) disable iff (!nrst)
		s_load_word |=> (applied_left_r == pend_left_r) && (applied_right_r == pend_right_r)
			##1 (left_gain_r == step_gain(applied_left_r));
	endproperty
	a_load_applies: assert property (p_load_applies)
		else $error("load flag did not apply both steps");

	property p_hold_keeps;
		@(posedge clk_sys) disable iff (!nrst)
		s_hold_word |=> $stable(applied_left_r) && $stable(applied_right_r)
			##1 $stable(left_gain_r);
	endproperty
	a_hold_keeps: assert property (p_hold_keeps)
		else $error("cleared load flag changed applied level");

	property p_both_together;
		@(posedge clk_sys) disable iff (!nrst)
		$changed(applied_left_r) || $changed(applied_right_r) |->
			$past(do_load) && (applied_right_r == $past(right_src));
	endproperty
	a_both_together: assert property (p_both_together)
		else $error("channels not updated in the same cycle");

	property p_gain_map;
		@(posedge clk_sys) disable iff (!nrst)
		1'b1 |=> left_gain_r == (($past(applied_left_r) == 8'hFF) ? 9'h100
		                         : {1'b0, $past(applied_left_r)});
	endproperty
	a_gain_map: assert property (p_gain_map)
		else $error("step to gain mapping wrong");

	property p_mode_write;
		@(posedge clk_sys) disable iff (!nrst)
		(latch_rise && word_addr == `DSCR_ADDR_MODE) |=>
			(mode_r == $past(shift_r[8:0])) && $stable(fmt_r);
	endproperty
	a_mode_write: assert property (p_mode_write)
		else $error("mode register not written from address 10");

	property p_fmt_write;
		@(posedge clk_sys) disable iff (!nrst)
		(latch_rise && word_addr == `DSCR_ADDR_FMT) |=>
			(fmt_r.rate_group_select == $past(shift_r[7:6])) &&
			(fmt_r.zero_detect_enable == $past(shift_r[8])) && $stable(mode_r);
	endproperty
	a_fmt_write: assert property (p_fmt_write)
		else $error("format register not written from address 11");

	property p_common_control;
		@(posedge clk_sys) disable iff (!nrst)
		fmt_r.atten_common_control ##1 fmt_r.atten_common_control |->
			right_gain_r == step_gain($past(applied_left_r));
	endproperty
	a_common_control: assert property (p_common_control)
		else $error("common control not using left step");

	property p_polarity;
		@(posedge clk_sys) disable iff (!nrst)
		1'b1 |=> chan_left_r == ($past(wclk_lvl) ^ $past(fmt_r.word_clock_polarity));
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("word clock phase assignment wrong");

	property p_right_gain_map;
		@(posedge clk_sys) disable iff (!nrst)
		1'b1 |=> right_gain_r == (($past(right_eff) == 8'hFF) ? 9'h100
		                          : {1'b0, $past(right_eff)});
	endproperty
	a_right_gain_map: assert property (p_right_gain_map)
		else $error("right step to gain mapping wrong");

	property p_individual_control;
		@(posedge clk_sys) disable iff (!nrst)
		!fmt_r.atten_common_control ##1 !fmt_r.atten_common_control |->
			right_gain_r == step_gain($past(applied_right_r));
	endproperty
	a_individual_control: assert property (p_individual_control)
		else $error("right channel not using its own step");

	property p_fmt_low_write;
		@(posedge clk_sys) disable iff (!nrst)
		(latch_rise && word_addr == `DSCR_ADDR_FMT) |=>
			(fmt_r.atten_common_control == $past(shift_r[2])) &&
			(fmt_r.word_clock_polarity == $past(shift_r[1])) &&
			(fmt_r.audio_format_select == $past(shift_r[0]));
	endproperty
	a_fmt_low_write: assert property (p_fmt_low_write)
		else $error("format low bits not taken from the word");

	property p_applied_needs_strobe;
		@(posedge clk_sys) disable iff (!nrst)
		!latch_rise |=> $stable(applied_left_r) && $stable(applied_right_r) &&
			$stable(pend_right_r);
	endproperty
	a_applied_needs_strobe: assert property (p_applied_needs_strobe)
		else $error("attenuation changed without a strobe");

endmodule : dscr_regs

// ---- dscr_cfg.svh ----
`ifndef DSCR_CFG_SVH
`define DSCR_CFG_SVH

// ----------------------------------------
// control word layout
// ----------------------------------------
`define DSCR_WORD_W        16
`define DSCR_ADDR_HI       10
`define DSCR_ADDR_LO       9
`define DSCR_LOAD_BIT      8
`define DSCR_STEP_HI       7
`define DSCR_MODE_HI       8
`define DSCR_FMT_BIT       0
`define DSCR_POL_BIT       1
`define DSCR_ATC_BIT       2
`define DSCR_RATE_LO       6
`define DSCR_RATE_HI       7
`define DSCR_ZDET_BIT      8

// ----------------------------------------
// register addresses
// ----------------------------------------
`define DSCR_ADDR_LEFT     2'h0
`define DSCR_ADDR_RIGHT    2'h1
`define DSCR_ADDR_MODE     2'h2
`define DSCR_ADDR_FMT      2'h3

// ----------------------------------------
// reset values, gain constants and synchroniser start-up count
// ----------------------------------------
`define DSCR_STEP_RST      8'hFF
`define DSCR_ROUTE_RST     4'h9
`define DSCR_SYS_RST       1'h1
`define DSCR_STEP_MAX      8'hFF
`define DSCR_GAIN_FULL     9'h100
`define DSCR_PRIME_CNT     2'h3

`endif

// ---- dscr_pkg.sv ----
package dscr_pkg;

	typedef enum logic [1:0] {
		DSCR_WL_16  = 2'b00,
		DSCR_WL_20  = 2'b01,
		DSCR_WL_24  = 2'b10,
		DSCR_WL_RES = 2'b11
	} dscr_wlen_t;

	typedef enum logic [1:0] {
		DSCR_SR_441 = 2'b00,
		DSCR_SR_48  = 2'b01,
		DSCR_SR_32  = 2'b10,
		DSCR_SR_RES = 2'b11
	} dscr_rate_t;

	typedef struct packed {
		logic [3:0] output_route_select;
		dscr_wlen_t word_length_select;
		logic       operation_enable;
		logic       deemphasis_enable;
		logic       soft_mute;
	} dscr_mode_t;

	typedef struct packed {
		logic       zero_detect_enable;
		dscr_rate_t rate_group_select;
		logic       atten_common_control;
		logic       word_clock_polarity;
		logic       audio_format_select;
	} dscr_fmt_t;

endpackage : dscr_pkg

// ---- dscr_sync.sv ----
`timescale 1ns/10ps
`include "dscr_cfg.svh"

module dscr_sync #(
	parameter int W = 4
) (
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise
);

	logic       primed_r;
	logic [1:0] prime_cnt_r;

	// ----------------------------------------
	// start-up: idle-high pins must not look like edges
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			prime_cnt_r <= 2'h0;
			primed_r    <= 1'b0;
		end else if (!primed_r) begin
			prime_cnt_r <= prime_cnt_r + 2'h1;
			primed_r    <= (prime_cnt_r == `DSCR_PRIME_CNT);
		end
	end

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_r, s2_r, s3_r, lvl_r, rise_r;
			wire  agree = (s2_r == s3_r);
			wire  lvl_nxt = agree ? s2_r : lvl_r;
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					s1_r   <= 1'b0;
					s2_r   <= 1'b0;
					s3_r   <= 1'b0;
					lvl_r  <= 1'b0;
					rise_r <= 1'b0;
				end else begin
					s1_r   <= async_in[i];
					s2_r   <= s1_r;
					s3_r   <= s2_r;
					lvl_r  <= lvl_nxt;
					rise_r <= primed_r & lvl_nxt & ~lvl_r;
				end
			end
			assign level[i] = lvl_r;
			assign rise[i]  = rise_r;
		end
	endgenerate

endmodule : dscr_sync

// ---- dscr_host_model.sv ----
`timescale 1ns/10ps

// ----------------------------------------
// host side of the three-wire control port
// ----------------------------------------
module dscr_host_model (
	output logic ctrl_serial_data,
	output logic ctrl_serial_clock,
	output logic ctrl_latch_strobe
);

	initial begin
		ctrl_serial_data  = 1'b0;
		ctrl_serial_clock = 1'b0;
		ctrl_latch_strobe = 1'b0;
	end

	// link clock stands still low between frames; slow doubles each half period
	task automatic send_word(input logic [15:0] w, input bit slow);
		real half;
		half = slow ? 125.0 : 62.5;
		// offset keeps every pin edge clear of a system clock edge
		#1;
		for (int i = 15; i >= 0; i--) begin
			ctrl_serial_data = w[i];
			#(half) ctrl_serial_clock = 1'b1;
			#(half) ctrl_serial_clock = 1'b0;
		end
		// released data line flips so a stale level cannot pass for a good one
		ctrl_serial_data = ~w[0];
		#(half) ctrl_latch_strobe = 1'b1;
		#(half) ctrl_latch_strobe = 1'b0;
		#(half);
	endtask : send_word

endmodule : dscr_host_model

// ---- dscr_regs_bench.sv ----
`timescale 1ns/10ps

module dscr_regs_bench;
	typedef struct packed {
		logic [8:0] lg;
		logic [8:0] rg;
		logic [8:0] md;
		logic [5:0] fm;
		logic       chl;
	} dscr_exp_t;

	logic                 clk_sys       = 1'b0;
	logic                 nrst          = 1'b0;
	logic                 word_clock_in = 1'b0;
	logic                 ctrl_serial_data;
	logic                 ctrl_serial_clock;
	logic                 ctrl_latch_strobe;
	logic [8:0]           left_gain;
	logic [8:0]           right_gain;
	dscr_pkg::dscr_mode_t mode_cfg;
	dscr_pkg::dscr_fmt_t  fmt_cfg;
	logic                 sysclk_ratio_select;
	logic                 channel_is_left;
	int                   fails     = 0;
	int                   cmp_count = 0;
	dscr_exp_t            exp_q[$];
	event                 obs_ev;
	logic [7:0]           lpend  = 8'hFF;
	logic [7:0]           rpend  = 8'hFF;
	logic [7:0]           lapp   = 8'hFF;
	logic [7:0]           rapp   = 8'hFF;
	logic [8:0]           mode_m = 9'h120;
	logic [5:0]           fmt_m  = 6'h00;

	always #5 clk_sys = ~clk_sys;

	dscr_host_model u_dscr_host_model (
		.ctrl_serial_data  (ctrl_serial_data),
		.ctrl_serial_clock (ctrl_serial_clock),
		.ctrl_latch_strobe (ctrl_latch_strobe)
	);

	dscr_regs u_dscr_regs (
		.clk_sys             (clk_sys),
		.nrst                (nrst),
		.ctrl_serial_data    (ctrl_serial_data),
		.ctrl_serial_clock   (ctrl_serial_clock),
		.ctrl_latch_strobe   (ctrl_latch_strobe),
		.word_clock_in       (word_clock_in),
		.left_gain           (left_gain),
		.right_gain          (right_gain),
		.mode_cfg            (mode_cfg),
		.fmt_cfg             (fmt_cfg),
		.sysclk_ratio_select (sysclk_ratio_select),
		.channel_is_left     (channel_is_left)
	);

	// ----------------------------------------
	// reference model and checks
	// ----------------------------------------
	function automatic logic [8:0] gain(input logic [7:0] x);
		return (x == 8'hFF) ? 9'h100 : {1'b0, x};
	endfunction : gain

	task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test

	// word clock moves between snapshots so the phase output is exercised
	task automatic snap();
		dscr_exp_t e;
		@(negedge clk_sys);
		word_clock_in = 1'($urandom);
		repeat (8) @(negedge clk_sys);
		e.lg  = gain(lapp);
		e.rg  = fmt_m[2] ? gain(lapp) : gain(rapp);
		e.md  = mode_m;
		e.fm  = fmt_m;
		e.chl = word_clock_in ^ fmt_m[1];
		exp_q.push_back(e);
		->obs_ev;
	endtask : snap

	task automatic write_reg(input logic [1:0] a, input logic [8:0] d, input logic [4:0] res,
		input bit slow);
		if (a == 2'h0) lpend = d[7:0];
		if (a == 2'h1) rpend = d[7:0];
		if (a[1] == 1'b0 && d[8]) begin
			lapp = lpend;
			rapp = rpend;
		end
		if (a == 2'h2) mode_m = d;
		if (a == 2'h3) fmt_m = {d[8:6], d[2:0]};
		u_dscr_host_model.send_word({res, a, d}, slow);
		snap();
	endtask : write_reg

	initial begin
		dscr_exp_t e;
		forever begin
			@(obs_ev);
			e = exp_q.pop_front();
			check("left_gain", left_gain, e.lg);
			check("right_gain", right_gain, e.rg);
			check("mode_cfg", mode_cfg, e.md);
			check("fmt_cfg", 9'(fmt_cfg), 9'(e.fm));
			check("sysclk_ratio", 9'(sysclk_ratio_select), 9'h001);
			check("channel_is_left", 9'(channel_is_left), 9'(e.chl));
		end
	end

	initial begin
		repeat (100000) @(posedge clk_sys);
		fails++;
		end_of_test();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] steps [4];
		steps = '{8'h00, 8'h01, 8'hFE, 8'hFF};
		void'($urandom(91833));
		repeat (16) @(negedge clk_sys);
		nrst = 1'b1;
		repeat (10) @(negedge clk_sys);
		snap();
		$display("test reset_defaults done");
		write_reg(2'h0, 9'h040, 5'h00, 1'b0);
		write_reg(2'h1, 9'h180, 5'h00, 1'b1);
		$display("test load_control done");
		foreach (steps[i]) begin
			write_reg(2'h0, {1'b1, steps[i]}, 5'h1F, 1'(i));
		end
		$display("test step_bounds done");
		for (int i = 0; i < 3; i++) begin
			write_reg(2'h2, {4'($urandom), i[1:0], 3'($urandom)}, 5'h00, 1'b0);
		end
		$display("test mode_fields done");
		for (int i = 0; i < 4; i++) begin
			write_reg(2'h3, {1'($urandom), i[1:0], 3'h7, 3'(i + 3)}, 5'h00, 1'b0);
		end
		$display("test format_fields done");
		repeat (12) begin
			write_reg(2'($urandom), 9'($urandom), 5'($urandom), 1'($urandom));
		end
		$display("test random_words done");
		end_of_test();
	end

endmodule : dscr_regs_bench
